/* hdl/rcf_cfg.svh */
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

// Register byte offsets and the mask of low address bits ignored in decoding.
`define RCF_VERSION_OFFSET  12'h000
`define RCF_CAP_LO_OFFSET   12'h008
`define RCF_CAP_HI_OFFSET   12'h00c
`define RCF_ADDR_MASK_LOW   12'h003

// Field positions in the 64-bit capability word and the version word.
`define RCF_READ_DRAIN_BIT  55
`define RCF_WRITE_DRAIN_BIT 54
`define RCF_MASK_MSB        53
`define RCF_MASK_LSB        48
`define RCF_FAULT_MSB       47
`define RCF_FAULT_LSB       40
`define RCF_PSI_BIT         39
`define RCF_RSVD_BIT        38
`define RCF_MAJOR_MSB       7
`define RCF_MAJOR_LSB       4

// Implementation constants.
`define RCF_MAJOR_VERSION   4'h2
`define RCF_MINOR_VERSION   4'h0
`define RCF_DRAIN_MAJOR     4'h2
`define RCF_MAX_MASK        6'h12
`define RCF_FAULT_RECORDS   9'h008
`define RCF_FAULT_LIMIT     9'h100
`define RCF_PSI_SUPPORT     1'b1
`define RCF_SCALABLE_MODE_TRANSLATION_SUPPORT_SUPPORT    1'b1
`define RCF_SL_1G_SUPPORT   1'b1
`define RCF_REC_MASK_4K     6'h09
`define RCF_REC_MASK_1G     6'h12
`define RCF_DRAIN_FIXED     1'b1
`define RCF_RDATA_RESET     32'h0000_0000

`endif

/* hdl/rcf_pkg.sv */
package rcf_pkg;

	typedef enum logic [1:0] {
		RCF_GRAN_GLOBAL,
		RCF_GRAN_DOMAIN,
		RCF_GRAN_PAGE
	} rcf_gran_type;

	typedef struct packed {
		rcf_gran_type gran;
		logic         second_level;
		logic         pasid_based;
		logic         read_drain;
		logic         write_drain;
		logic [5:0]   invalidate_address_mask;
	} rcf_inv_req_type;

	typedef struct packed {
		logic done;
		logic accepted;
		logic read_drain;
		logic write_drain;
	} rcf_inv_res_type;

endpackage

/* hdl/rcf_cap.sv */
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_cfg.svh"

module rcf_cap (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output var  logic                     hreadyout,
	output var  logic [31:0]              hrdata,
	output var  logic                     hresp,
	input  wire logic                     inv_valid,
	input  wire rcf_pkg::rcf_inv_req_type inv_req,
	output var  rcf_pkg::rcf_inv_res_type inv_res
);
	import rcf_pkg::*;

	// ----------------------------------------------------------------
	// Constant register images
	// ----------------------------------------------------------------

	// The whole capability word is wired from constants, so nothing a
	// write does can reach it.
	logic [63:0] cap_word;
	logic [31:0] version_word;
	logic [7:0]  fault_code;

	assign fault_code = 8'(`RCF_FAULT_RECORDS - 9'h001);

	always_comb begin
		cap_word = 64'h0;
		cap_word[`RCF_READ_DRAIN_BIT] = `RCF_DRAIN_FIXED;
		cap_word[`RCF_WRITE_DRAIN_BIT] = `RCF_DRAIN_FIXED;
		cap_word[`RCF_MASK_MSB:`RCF_MASK_LSB] = `RCF_MAX_MASK;
		cap_word[`RCF_FAULT_MSB:`RCF_FAULT_LSB] = fault_code;
		cap_word[`RCF_PSI_BIT] = `RCF_PSI_SUPPORT;
		cap_word[`RCF_RSVD_BIT] = 1'b0;
	end

	always_comb begin
		version_word = 32'h0;
		version_word[`RCF_MAJOR_MSB:`RCF_MAJOR_LSB] = `RCF_MAJOR_VERSION;
		version_word[3:0] = `RCF_MINOR_VERSION;
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------

	// Zero wait states: read data is chosen in the address phase and
	// registered, so it stands in the following data phase.
	logic        addr_phase;
	logic        rd_phase;
	logic [11:0] word_addr;
	logic [31:0] next_hrdata;

	assign addr_phase = hsel && hready && htrans[1];
	assign rd_phase = addr_phase && !hwrite;
	assign word_addr = haddr[11:0] & ~`RCF_ADDR_MASK_LOW;

	always_comb begin
		next_hrdata = `RCF_RDATA_RESET;
		if (rd_phase) begin
			unique case (word_addr)
				`RCF_VERSION_OFFSET: next_hrdata = version_word;
				`RCF_CAP_LO_OFFSET: next_hrdata = cap_word[31:0];
				`RCF_CAP_HI_OFFSET: next_hrdata = cap_word[63:32];
				default: next_hrdata = `RCF_RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `RCF_RDATA_RESET;
		end else if (hready) begin
			hrdata <= next_hrdata;
		end
	end

	// Writes complete with OKAY and are dropped; reads leave no trace.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Invalidation acceptance and draining
	// ----------------------------------------------------------------

	logic major_drains;
	logic next_accept;
	logic sl_mask_ok;

	assign major_drains = (`RCF_MAJOR_VERSION >= `RCF_DRAIN_MAJOR);
	// A second-level mask above the reported maximum is refused; the
	// caller still sees done, so it never waits on a dropped request.
	assign sl_mask_ok = inv_req.invalidate_address_mask <= `RCF_MAX_MASK;

	always_comb begin
		next_accept = 1'b1;
		unique case (inv_req.gran)
			RCF_GRAN_GLOBAL: next_accept = 1'b1;
			RCF_GRAN_DOMAIN: next_accept = 1'b1;
			RCF_GRAN_PAGE: begin
				if (inv_req.pasid_based) begin
					next_accept = `RCF_SCALABLE_MODE_TRANSLATION_SUPPORT_SUPPORT;
				end else if (!inv_req.second_level) begin
					next_accept = `RCF_SCALABLE_MODE_TRANSLATION_SUPPORT_SUPPORT;
				end else begin
					next_accept = `RCF_PSI_SUPPORT && sl_mask_ok;
				end
			end
			default: next_accept = 1'b0;
		endcase
	end

	// A newer major version drains whether or not software asked for it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inv_res <= '0;
		end else begin
			inv_res.done <= inv_valid;
			inv_res.accepted <= inv_valid && next_accept;
			inv_res.read_drain <= inv_valid && next_accept
				&& (inv_req.read_drain || major_drains);
			inv_res.write_drain <= inv_valid && next_accept
				&& (inv_req.write_drain || major_drains);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	// Register reads are checked against images rebuilt from the macros,
	// not against cap_word, so a slip in the wiring of the image shows up.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_cap_hi_read;
		rd_phase && (word_addr == `RCF_CAP_HI_OFFSET) ##1 hready;
	endsequence

	sequence s_cap_lo_read;
		rd_phase && (word_addr == `RCF_CAP_LO_OFFSET) ##1 hready;
	endsequence

	sequence s_ver_read;
		rd_phase && (word_addr == `RCF_VERSION_OFFSET) ##1 hready;
	endsequence

	sequence s_write_then_hi_read;
		addr_phase && hwrite ##[1:2] rd_phase && (word_addr == `RCF_CAP_HI_OFFSET);
	endsequence

	sequence s_unmapped_read;
		rd_phase && (word_addr != `RCF_VERSION_OFFSET)
			&& (word_addr != `RCF_CAP_LO_OFFSET)
			&& (word_addr != `RCF_CAP_HI_OFFSET) ##1 hready;
	endsequence

	property p_drain_bits;
		s_cap_hi_read |-> hrdata[23:22] == 2'b11;
	endproperty
	a_drain_bits: assert property (p_drain_bits)
		else $error("Draining bits do not read as one.");

	property p_mask_field;
		s_cap_hi_read |-> hrdata[21:16] == `RCF_MAX_MASK;
	endproperty
	a_mask_field: assert property (p_mask_field)
		else $error("Maximum mask field is wrong.");

	property p_fault_field;
		s_cap_hi_read |-> ({1'b0, hrdata[15:8]} + 9'h001) == `RCF_FAULT_RECORDS;
	endproperty
	a_fault_field: assert property (p_fault_field)
		else $error("Fault register count field is wrong.");

	property p_psi_rsvd;
		s_cap_hi_read |-> hrdata[7] == `RCF_PSI_SUPPORT && !hrdata[6];
	endproperty
	a_psi_rsvd: assert property (p_psi_rsvd)
		else $error("Page-selective or reserved bit is wrong.");

	property p_cap_lo_zero;
		s_cap_lo_read |-> hrdata == 32'h0000_0000;
	endproperty
	a_cap_lo_zero: assert property (p_cap_lo_zero)
		else $error("Unimplemented low capability bits are not zero.");

	property p_version_major;
		s_ver_read |-> hrdata[7:4] == `RCF_MAJOR_VERSION;
	endproperty
	a_version_major: assert property (p_version_major)
		else $error("Major version field is wrong.");

	property p_write_no_effect;
		s_write_then_hi_read |=> hrdata == {8'h00, `RCF_DRAIN_FIXED, `RCF_DRAIN_FIXED,
			`RCF_MAX_MASK, 8'(`RCF_FAULT_RECORDS - 9'h001), `RCF_PSI_SUPPORT, 1'b0, 6'h00};
	endproperty
	a_write_no_effect: assert property (p_write_no_effect)
		else $error("A write changed the capability word.");

	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay)
		else $error("Slave gave a wait state or an error.");

	property p_mandatory_drain;
		inv_valid && major_drains |=> inv_res.read_drain == inv_res.accepted
			&& inv_res.write_drain == inv_res.accepted;
	endproperty
	a_mandatory_drain: assert property (p_mandatory_drain)
		else $error("Accepted invalidation did not drain.");

	property p_pasid_any_mask;
		inv_valid && inv_req.gran == RCF_GRAN_PAGE && inv_req.pasid_based
			&& `RCF_SCALABLE_MODE_TRANSLATION_SUPPORT_SUPPORT |=> inv_res.accepted && inv_res.done;
	endproperty
	a_pasid_any_mask: assert property (p_pasid_any_mask)
		else $error("Process-tagged invalidation was refused.");

	property p_first_level;
		inv_valid && inv_req.gran == RCF_GRAN_PAGE && !inv_req.pasid_based
			&& !inv_req.second_level && `RCF_SCALABLE_MODE_TRANSLATION_SUPPORT_SUPPORT |=> inv_res.accepted;
	endproperty
	a_first_level: assert property (p_first_level)
		else $error("First-level page invalidation was refused.");

	property p_sl_mask_limit;
		inv_valid && inv_req.gran == RCF_GRAN_PAGE && !inv_req.pasid_based
			&& inv_req.second_level && `RCF_PSI_SUPPORT
			&& inv_req.invalidate_address_mask <= `RCF_MAX_MASK |=> inv_res.accepted;
	endproperty
	a_sl_mask_limit: assert property (p_sl_mask_limit)
		else $error("Second-level mask limit misapplied.");

	property p_sl_mask_over;
		inv_valid && inv_req.gran == RCF_GRAN_PAGE && !inv_req.pasid_based
			&& inv_req.second_level && inv_req.invalidate_address_mask > `RCF_MAX_MASK
			|=> inv_res.done && !inv_res.accepted
			&& !inv_res.read_drain && !inv_res.write_drain;
	endproperty
	a_sl_mask_over: assert property (p_sl_mask_over)
		else $error("Mask above the reported maximum was accepted.");

	property p_fault_range;
		`RCF_FAULT_RECORDS >= 9'h001 && `RCF_FAULT_RECORDS <= `RCF_FAULT_LIMIT;
	endproperty
	a_fault_range: assert property (p_fault_range)
		else $error("Fault register count out of range.");

	property p_rec_mask;
		`RCF_PSI_SUPPORT |-> `RCF_MAX_MASK >=
			(`RCF_SL_1G_SUPPORT ? `RCF_REC_MASK_1G : `RCF_REC_MASK_4K);
	endproperty
	a_rec_mask: assert property (p_rec_mask)
		else $error("Maximum mask below recommended value.");

	property p_idle_result;
		!inv_valid |=> !inv_res.done && !inv_res.accepted;
	endproperty
	a_idle_result: assert property (p_idle_result)
		else $error("Invalidation result without a request.");

	property p_global_domain;
		inv_valid && (inv_req.gran == RCF_GRAN_GLOBAL
			|| inv_req.gran == RCF_GRAN_DOMAIN) |=> inv_res.done && inv_res.accepted;
	endproperty
	a_global_domain: assert property (p_global_domain)
		else $error("Global or domain invalidation was refused.");

	property p_inv_answer;
		inv_valid |=> inv_res.done;
	endproperty
	a_inv_answer: assert property (p_inv_answer)
		else $error("Invalidation request got no answer.");

	property p_drain_needs_accept;
		!inv_res.accepted |-> !inv_res.read_drain && !inv_res.write_drain;
	endproperty
	a_drain_needs_accept: assert property (p_drain_needs_accept)
		else $error("Drain reported for a refused invalidation.");

	property p_version_rest;
		s_ver_read |-> hrdata[31:8] == 24'h00_0000
			&& hrdata[3:0] == `RCF_MINOR_VERSION;
	endproperty
	a_version_rest: assert property (p_version_rest)
		else $error("Version word outside the major field is wrong.");

	property p_unmapped_zero;
		s_unmapped_read |-> hrdata == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("Unmapped register offset did not read zero.");

	property p_idle_clear;
		hready && !rd_phase |=> hrdata == `RCF_RDATA_RESET;
	endproperty
	a_idle_clear: assert property (p_idle_clear)
		else $error("Read data left standing after a non-read cycle.");

	property p_cap_hi_upper;
		s_cap_hi_read |-> hrdata[31:24] == 8'h00;
	endproperty
	a_cap_hi_upper: assert property (p_cap_hi_upper)
		else $error("Capability bits above the draining bits are not zero.");

	property p_write_okay;
		addr_phase && hwrite |=> hreadyout && !hresp;
	endproperty
	a_write_okay: assert property (p_write_okay)
		else $error("Write to a read-only register was not completed OKAY.");

endmodule

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import rcf_pkg::*;

	// ----------------------------------------------------------------
	// Signals and case rows
	// ----------------------------------------------------------------
	typedef struct packed {
		logic            is_inv;
		logic [31:0]     addr;
		logic [31:0]     exp;
		rcf_inv_req_type req;
	} rcf_row_type;

	logic            hclk;
	logic            hresetn;
	logic            hsel;
	logic [31:0]     haddr;
	logic [1:0]      htrans;
	logic            hwrite;
	logic [2:0]      hsize;
	logic [31:0]     hwdata;
	logic            hreadyout;
	logic [31:0]     hrdata;
	logic            hresp;
	logic            inv_valid;
	rcf_inv_req_type inv_req;
	rcf_inv_res_type inv_res;
	logic [31:0]     rdat;
	int              error_cnt = 0;
	int              tests_run = 0;
	rcf_row_type     rows[$];

	rcf_cap rcf_cap_i (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.inv_valid (inv_valid),
		.inv_req   (inv_req),
		.inv_res   (inv_res)
	);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks run %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_res(input string name, input rcf_inv_res_type exp,
		input rcf_inv_res_type got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %b seen %b", name, exp, got);
		end
	endtask

	// One single word transfer; waits rely on the watchdog, not on a cycle count.
	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic inv(input rcf_inv_req_type r);
		inv_valid <= 1'b1;
		inv_req <= r;
		@(posedge hclk);
		inv_valid <= 1'b0;
		@(posedge hclk);
	endtask

	// Drain request bits stay clear so that any drain seen is forced by the device.
	function automatic rcf_inv_req_type mk(rcf_gran_type g, logic sl, logic pb, logic [5:0] m);
		return {g, sl, pb, 2'b00, m};
	endfunction

	function automatic void add(logic i, logic [31:0] a, logic [31:0] e, rcf_inv_req_type r);
		rows.push_back({i, a, e, r});
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		inv_valid = 1'b0;
		inv_req = '0;
		repeat (10) @(posedge hclk);
		chk("hreadyout in reset", 32'h1, {31'h0, hreadyout});
		chk("hrdata in reset", 32'h0, hrdata);
		chk_res("inv_res in reset", 4'h0, inv_res);
		hresetn <= 1'b1;
		@(posedge hclk);
		add(1'b0, 32'h000, 32'h0000_0020, '0);
		add(1'b0, 32'h008, 32'h0000_0000, '0);
		add(1'b0, 32'h00c, 32'h00d2_0780, '0);
		add(1'b0, 32'h004, 32'h0000_0000, '0);
		add(1'b0, 32'h010, 32'h0000_0000, '0);
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_GLOBAL, 1'b1, 1'b0, 6'h3f));
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_DOMAIN, 1'b1, 1'b0, 6'h3f));
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_PAGE, 1'b1, 1'b0, 6'h00));
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_PAGE, 1'b1, 1'b0, 6'h12));
		add(1'b1, 32'h0, 32'h0, mk(RCF_GRAN_PAGE, 1'b1, 1'b0, 6'h13));
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_PAGE, 1'b1, 1'b1, 6'h3f));
		add(1'b1, 32'h0, 32'h1, mk(RCF_GRAN_PAGE, 1'b0, 1'b0, 6'h3f));
		foreach (rows[i]) begin
			if (rows[i].is_inv) begin
				inv(rows[i].req);
				chk_res("inv_res", {1'b1, {3{rows[i].exp[0]}}}, inv_res);
			end else begin
				ahb(rows[i].addr, 1'b0, 32'h0, rdat);
				chk("hrdata", rows[i].exp, rdat);
			end
		end
		// Writes, including ones to the reserved bit, must change nothing.
		ahb(32'h00c, 1'b1, 32'hffff_ffff, rdat);
		ahb(32'h000, 1'b1, 32'h0000_0000, rdat);
		ahb(32'h00c, 1'b0, 32'h0, rdat);
		chk("cap high after write", 32'h00d2_0780, rdat);
		chk("psi read before mask", 32'h1, {31'h0, rdat[7]});
		chk("mask after psi", 32'h12, {26'h0, rdat[21:16]});
		ahb(32'h000, 1'b0, 32'h0, rdat);
		chk("version after write", 32'h0000_0020, rdat);
		// Back to back requests: refused then accepted, each answer one cycle.
		inv_valid <= 1'b1;
		inv_req <= {RCF_GRAN_PAGE, 1'b1, 1'b0, 2'b11, 6'h13};
		@(posedge hclk);
		inv_req <= mk(RCF_GRAN_GLOBAL, 1'b1, 1'b0, 6'h00);
		@(posedge hclk);
		inv_valid <= 1'b0;
		chk_res("inv_res refused", 4'b1000, inv_res);
		@(posedge hclk);
		chk_res("inv_res accepted", 4'b1111, inv_res);
		@(posedge hclk);
		chk_res("inv_res idle", 4'b0000, inv_res);
		// Reset lands in the data phase of a read and on an invalidation answer;
		// both must clear at once, not at the next clock edge.
		hsel <= 1'b1;
		haddr <= 32'h00c;
		htrans <= 2'b10;
		hwrite <= 1'b0;
		inv_valid <= 1'b1;
		inv_req <= mk(RCF_GRAN_GLOBAL, 1'b0, 1'b0, 6'h00);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		inv_valid <= 1'b0;
		hresetn <= 1'b0;
		#1;
		chk("hrdata in second reset", 32'h0, hrdata);
		chk_res("inv_res in second reset", 4'h0, inv_res);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("hreadyout after reset", 32'h1, {31'h0, hreadyout});
		chk_res("inv_res after reset", 4'h0, inv_res);
		ahb(32'h00c, 1'b0, 32'h0, rdat);
		chk("cap high after reset", 32'h00d2_0780, rdat);
		test_done;
	end

	initial begin
		repeat (2000) @(posedge hclk);
		error_cnt++;
		test_done;
	end
endmodule

`default_nettype wire
